// ### macrocell_pkg.sv
// Package with map, field positions, reset values and mode codes of the logic array block
package macrocell_pkg;
   // Register byte addresses
   localparam logic [7:0] ADDR_CONTROL = 8'h00;   // Mode select and protect
   localparam logic [7:0] ADDR_CELL_CFG = 8'h04;  // Polarity and registered bits
   localparam logic [7:0] ADDR_PROG_ADDR = 8'h08; // Row and column address
   localparam logic [7:0] ADDR_PROG_CMD = 8'h0c;  // Programming step and data
   localparam logic [7:0] ADDR_STATUS = 8'h10;    // Cell state and verify data
   localparam logic [7:0] ADDR_ID = 8'h14;        // Block identity
   // Control fields
   localparam int CTRL_MODE_LSB = 0;              // Three bits of mode
   localparam int CTRL_PROTECT_BIT = 4;           // Write 1 programs read-protect
   // Cell config fields
   localparam int CFG_POL_LSB = 0;                // Ten polarity_select_bit
   localparam int CFG_REG_LSB = 16;               // Ten registered_select_bit
   // Programming command fields
   localparam int CMD_STEP_LSB = 0;               // Two bits of step
   localparam int CMD_DATA_BIT = 4;               // Data bit from I/O pin
   localparam int CMD_ARRAY_LSB = 8;              // Target array
   // Address fields
   localparam int ROW_LSB = 0;
   localparam int COL_LSB = 8;
   // Reset values
   localparam logic [31:0] CELL_CFG_RESET = 32'h0000_0000;
   localparam logic [31:0] ID_VALUE = 32'h0000_5a01; // Arbitrary value
   // Sizes
   localparam int NUM_CELLS = 10;
   localparam int NUM_INPUTS = 12;
   localparam int NUM_TEST_COLS = 4;
   localparam int NUM_TERMS = 12;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Operating modes
   typedef enum logic [2:0] {
      MODE_NORMAL = 3'h0,
      MODE_TEST_ARRAY = 3'h1,
      MODE_UPPER_TEST = 3'h2,
      MODE_LOWER_TEST = 3'h3,
      MODE_PRELOAD = 3'h4
   } op_mode_t;
   // Targets of programming
   typedef enum logic [1:0] {
      ARR_NORMAL = 2'h0,
      ARR_TEST = 2'h1,
      ARR_UPPER_LOWER = 2'h2
   } array_sel_t;
   // Programming sequence, one-hot
   typedef enum logic [3:0] {
      PS_IDLE = 4'b0001,
      PS_PROGRAM = 4'b0010,
      PS_INHIBIT = 4'b0100,
      PS_VERIFY = 4'b1000
   } prog_state_t;
   // Programming step codes
   localparam logic [1:0] STEP_PROGRAM = 2'h1;
   localparam logic [1:0] STEP_INHIBIT = 2'h2;
   localparam logic [1:0] STEP_VERIFY = 2'h3;
endpackage

// ### logic_array_top.sv
// Logic array with ten output cells, programming sequencer and AXI4-Lite slave
// Notes on behaviour
// - Protect bit blocks normal and upper/lower access, test array stays open
// - Ten independent cells, one pin each
// - Cell has flop, selectors, per-cell enable term
// - One common clock for every cell
// - Shared sync reset and sync preset terms
// - Registers reset at power up
// - Registers low after power up
// - Polarity bit and registered bit per cell
// - Feedback from register or from pin
// - No buried register with combinatorial pin
// - Combinatorial, disabled cell acts as input
// - Test array adds four columns, one inverting
// - Test structures idle in normal operation
// - Upper/lower test term drives one pin
// - Data 1 programs, 0 leaves unprogrammed
// - Program, inhibit, verify; protect has no inhibit
// - Five operating modes besides programming
// - Normal mode uses normal array
// - Test array mode; blank cells registered inverted
// - Preload tri-states drivers, loads pins on edge
// - Preload stores the pin value
// - Preload loads on rising clock edge
`timescale 1ns/10ps
module logic_array_top #(
   parameter int CELLS = macrocell_pkg::NUM_CELLS,
   parameter int INPUTS = macrocell_pkg::NUM_INPUTS
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Dedicated logic inputs
   input wire logic [INPUTS-1:0] logic_in,
   // Cell pins
   input wire logic [CELLS-1:0] pin_in,
   output logic [CELLS-1:0] pin_out,
   output logic [CELLS-1:0] pin_oe,
   // AXI4-Lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam int COLS = 2 * (INPUTS + CELLS);   // True and complement columns
   localparam int TCOL = macrocell_pkg::NUM_TEST_COLS;

   // Reset release synchroniser, also the power-up reset
   logic rst_meta_r, rst_sync_r;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end
   wire logic rst_n = rst_sync_r;

   // Pin and input synchronisers; first stage read only by second
   logic [CELLS-1:0] pin_meta_r, pin_s_r;
   logic [INPUTS-1:0] in_meta_r, in_s_r;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_r <= '0;
         pin_s_r <= '0;
         in_meta_r <= '0;
         in_s_r <= '0;
      end else begin
         pin_meta_r <= pin_in;
         pin_s_r <= pin_meta_r;
         in_meta_r <= logic_in;
         in_s_r <= in_meta_r;
      end
   end

   // Software state
   logic [2:0] mode_r;                          // Operating mode
   logic protect_r;                             // Read-protect bit, sticky
   logic [CELLS-1:0] pol_r, regsel_r;           // Cell architecture bits
   logic [7:0] row_r, col_r;                    // Programming address
   // Fuse storage: normal terms, enable terms, reset, preset, test array, test terms
   logic [COLS-1:0] and_fuse_r [CELLS][macrocell_pkg::NUM_TERMS];
   logic [COLS-1:0] oe_fuse_r [CELLS];
   logic [COLS-1:0] ar_fuse_r, sp_fuse_r;
   logic [TCOL-1:0] tst_fuse_r [CELLS];          // Test columns onto each cell's terms
   logic [INPUTS-1:0] ul_fuse_r [2];            // Upper and lower test terms
   logic verify_bit_r;                          // Last verify read-back
   logic [CELLS-1:0] q_r;                       // Cell registers
   macrocell_pkg::prog_state_t ps_r, ps_nxt;

   // Modes, decoded once
   wire logic m_test = (mode_r == macrocell_pkg::MODE_TEST_ARRAY);
   wire logic m_upper = (mode_r == macrocell_pkg::MODE_UPPER_TEST);
   wire logic m_lower = (mode_r == macrocell_pkg::MODE_LOWER_TEST);
   wire logic m_pre = (mode_r == macrocell_pkg::MODE_PRELOAD);

   // Feedback: register in registered mode, pin otherwise; no buried mode exists
   wire logic [CELLS-1:0] fb = (regsel_r & q_r) | (~regsel_r & pin_s_r);
   wire logic [INPUTS+CELLS-1:0] sig = {fb, in_s_r};
   wire logic [COLS-1:0] cols = {~sig, sig};

   // A product term is true when every connected column is high; blank term is false
   function automatic logic pterm(input logic [COLS-1:0] f, input logic [COLS-1:0] c);
      pterm = (|f) && ((c & f) == f);
   endfunction

   // Test columns: three true inputs and one inverting
   wire logic [TCOL-1:0] tcols = {in_s_r[10], in_s_r[9], ~in_s_r[6], in_s_r[1]};

   // Per-cell sum, enable and next-state logic
   logic [CELLS-1:0] sum, oe_t, d_val, cell_out, blank;
   genvar gi;
   generate
      for (gi = 0; gi < CELLS; gi++) begin : g_cell
         logic [macrocell_pkg::NUM_TERMS-1:0] terms;
         for (genvar t = 0; t < macrocell_pkg::NUM_TERMS; t++) begin : g_term
            assign terms[t] = pterm(and_fuse_r[gi][t], cols);
         end
         // Test array only contributes in its own mode
         wire logic tst = m_test && ((tst_fuse_r[gi] & tcols) == tst_fuse_r[gi])
                          && (|tst_fuse_r[gi]);
         assign sum[gi] = m_test ? tst : (|terms);
         assign oe_t[gi] = pterm(oe_fuse_r[gi], cols);
         assign blank[gi] = m_test && !regsel_r[gi] && !pol_r[gi];
         // Blank cells in test mode behave registered and inverting
         wire logic regm = regsel_r[gi] | blank[gi];
         wire logic pol = pol_r[gi] | blank[gi];
         // Output selector then polarity
         assign cell_out[gi] = (regm ? q_r[gi] : sum[gi]) ^ pol;
         // Preload takes the pin, else sum; reset and preset terms act in the register
         assign d_val[gi] = m_pre ? pin_s_r[gi] : sum[gi];
      end
   endgenerate

   wire logic ar_t = pterm(ar_fuse_r, cols);
   wire logic sp_t = pterm(sp_fuse_r, cols);
   wire logic up_t = ((ul_fuse_r[0] & in_s_r) == ul_fuse_r[0]) && (|ul_fuse_r[0]);
   wire logic lo_t = ((ul_fuse_r[1] & in_s_r) == ul_fuse_r[1]) && (|ul_fuse_r[1]);

   // Cell registers on the one common clock; reset term clears on the next edge
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q_r <= '0;
      end else if (ar_t && !m_pre) begin
         q_r <= '0;
      end else if (sp_t && !m_pre) begin
         q_r <= '1;
      end else begin
         q_r <= d_val;
      end
   end

   // Pin drivers: upper test takes the last pin, lower test the first, preload floats all
   logic [CELLS-1:0] po_nxt, oe_nxt;
   always_comb begin
      po_nxt = cell_out;
      oe_nxt = oe_t;
      if (m_pre) begin
         oe_nxt = '0;
      end
      if (m_upper) begin
         po_nxt[CELLS-1] = up_t;
         oe_nxt[CELLS-1] = 1'b1;
      end
      if (m_lower) begin
         po_nxt[0] = lo_t;
         oe_nxt[0] = 1'b1;
      end
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pin_out <= '0;
         pin_oe <= '0;
      end else begin
         pin_out <= po_nxt;
         pin_oe <= oe_nxt;
      end
   end

   // AXI4-Lite write channel, both address and data may arrive in any order
   logic aw_have_r, w_have_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   wire logic wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
   wire logic wr_hit = (aw_addr_r == macrocell_pkg::ADDR_CONTROL) ||
                       (aw_addr_r == macrocell_pkg::ADDR_CELL_CFG) ||
                       (aw_addr_r == macrocell_pkg::ADDR_PROG_ADDR) ||
                       (aw_addr_r == macrocell_pkg::ADDR_PROG_CMD);
   wire logic do_ctrl = wr_go && aw_addr_r == macrocell_pkg::ADDR_CONTROL && w_strb_r[0];
   wire logic do_cfg = wr_go && aw_addr_r == macrocell_pkg::ADDR_CELL_CFG;
   wire logic do_addr = wr_go && aw_addr_r == macrocell_pkg::ADDR_PROG_ADDR;
   wire logic do_cmd = wr_go && aw_addr_r == macrocell_pkg::ADDR_PROG_CMD && w_strb_r[0];
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= '0;
         w_data_r <= '0;
         w_strb_r <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= macrocell_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= !w_have_r && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? macrocell_pkg::RESP_OKAY : macrocell_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Control, cell configuration and address registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mode_r <= macrocell_pkg::MODE_NORMAL;
         protect_r <= 1'b0;
         pol_r <= '0;
         regsel_r <= '0;
         row_r <= '0;
         col_r <= '0;
      end else begin
         if (do_ctrl) begin
            mode_r <= (w_data_r[macrocell_pkg::CTRL_MODE_LSB +: 3] > 3'h4) ?
                      mode_r : w_data_r[macrocell_pkg::CTRL_MODE_LSB +: 3];
            // Protect programs directly, no inhibit step; only a reset clears it
            if (w_data_r[macrocell_pkg::CTRL_PROTECT_BIT]) begin
               protect_r <= 1'b1;
            end
         end
         if (do_cfg && !protect_r) begin
            pol_r <= w_data_r[macrocell_pkg::CFG_POL_LSB +: CELLS];
            regsel_r <= w_data_r[macrocell_pkg::CFG_REG_LSB +: CELLS];
         end
         if (do_addr) begin
            row_r <= w_data_r[macrocell_pkg::ROW_LSB +: 8];
            col_r <= w_data_r[macrocell_pkg::COL_LSB +: 8];
         end
      end
   end

   // Programming sequence: program, then inhibit, then verify
   wire logic [1:0] cmd_step = w_data_r[macrocell_pkg::CMD_STEP_LSB +: 2];
   wire logic cmd_data = w_data_r[macrocell_pkg::CMD_DATA_BIT];
   wire logic [1:0] cmd_arr = w_data_r[macrocell_pkg::CMD_ARRAY_LSB +: 2];
   // Protected arrays refuse access; the test array stays open
   wire logic allowed = !protect_r || (cmd_arr == macrocell_pkg::ARR_TEST);
   always_comb begin
      ps_nxt = ps_r;
      if (do_cmd) begin
         unique case (ps_r)
            macrocell_pkg::PS_IDLE, macrocell_pkg::PS_VERIFY:
               ps_nxt = (cmd_step == macrocell_pkg::STEP_PROGRAM) ?
                        macrocell_pkg::PS_PROGRAM : ps_r;
            macrocell_pkg::PS_PROGRAM:
               ps_nxt = (cmd_step == macrocell_pkg::STEP_INHIBIT) ?
                        macrocell_pkg::PS_INHIBIT : ps_r;
            macrocell_pkg::PS_INHIBIT:
               ps_nxt = (cmd_step == macrocell_pkg::STEP_VERIFY) ?
                        macrocell_pkg::PS_VERIFY : ps_r;
         endcase
      end
   end
   wire logic do_prog = do_cmd && allowed && ps_r != macrocell_pkg::PS_PROGRAM &&
                        cmd_step == macrocell_pkg::STEP_PROGRAM && cmd_data;
   wire logic do_verify = do_cmd && ps_r == macrocell_pkg::PS_INHIBIT &&
                          cmd_step == macrocell_pkg::STEP_VERIFY;
   wire logic [3:0] cell_i = row_r[7:4];
   wire logic [3:0] term_i = row_r[3:0];
   wire logic [7:0] col_i = col_r;
   logic fuse_rd;
   always_comb begin
      fuse_rd = 1'b0;
      if (cmd_arr == macrocell_pkg::ARR_TEST) begin
         fuse_rd = tst_fuse_r[cell_i % CELLS][col_i % TCOL];
      end else if (cmd_arr == macrocell_pkg::ARR_UPPER_LOWER) begin
         fuse_rd = ul_fuse_r[row_r[0]][col_i % INPUTS];
      end else if (term_i == 4'he) begin
         fuse_rd = ar_fuse_r[col_i % COLS];
      end else if (term_i == 4'hf) begin
         fuse_rd = sp_fuse_r[col_i % COLS];
      end else if (term_i == 4'hd) begin
         fuse_rd = oe_fuse_r[cell_i % CELLS][col_i % COLS];
      end else begin
         fuse_rd = and_fuse_r[cell_i % CELLS][term_i % macrocell_pkg::NUM_TERMS][col_i % COLS];
      end
   end

   // Fuses clear on every reset and otherwise only ever get programmed
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ps_r <= macrocell_pkg::PS_IDLE;
         verify_bit_r <= 1'b0;
         ar_fuse_r <= '0;
         sp_fuse_r <= '0;
         ul_fuse_r <= '{default: '0};
         tst_fuse_r <= '{default: '0};
         oe_fuse_r <= '{default: '0};
         and_fuse_r <= '{default: '0};
      end else begin
         ps_r <= ps_nxt;
         if (do_verify) begin
            verify_bit_r <= allowed ? fuse_rd : 1'b0;
         end
         if (do_prog) begin
            if (cmd_arr == macrocell_pkg::ARR_TEST) begin
               tst_fuse_r[cell_i % CELLS][col_i % TCOL] <= 1'b1;
            end else if (cmd_arr == macrocell_pkg::ARR_UPPER_LOWER) begin
               ul_fuse_r[row_r[0]][col_i % INPUTS] <= 1'b1;
            end else if (term_i == 4'he) begin
               ar_fuse_r[col_i % COLS] <= 1'b1;
            end else if (term_i == 4'hf) begin
               sp_fuse_r[col_i % COLS] <= 1'b1;
            end else if (term_i == 4'hd) begin
               oe_fuse_r[cell_i % CELLS][col_i % COLS] <= 1'b1;
            end else begin
               and_fuse_r[cell_i % CELLS][term_i % macrocell_pkg::NUM_TERMS][col_i % COLS] <= 1'b1;
            end
         end
      end
   end

   // Read data mux
   wire logic [31:0] rd_word =
      (s_axi_araddr == macrocell_pkg::ADDR_CONTROL) ?
         {27'h0, protect_r, 1'b0, mode_r} :
      (s_axi_araddr == macrocell_pkg::ADDR_CELL_CFG) ?
         {6'h0, regsel_r, 6'h0, pol_r} :
      (s_axi_araddr == macrocell_pkg::ADDR_PROG_ADDR) ? {16'h0, col_r, row_r} :
      (s_axi_araddr == macrocell_pkg::ADDR_PROG_CMD) ? {28'h0, ps_r} :
      (s_axi_araddr == macrocell_pkg::ADDR_STATUS) ?
         {5'h0, verify_bit_r, q_r, 6'h0, pin_s_r} :
      (s_axi_araddr == macrocell_pkg::ADDR_ID) ? macrocell_pkg::ID_VALUE : 32'h0;
   wire logic rd_hit = (s_axi_araddr <= macrocell_pkg::ADDR_ID) && (s_axi_araddr[1:0] == 2'h0);

   // AXI4-Lite read channel, one read at a time
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= macrocell_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_hit ? rd_word : 32'h0;
            s_axi_rresp <= rd_hit ? macrocell_pkg::RESP_OKAY : macrocell_pkg::RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule

// ### pin_model.sv
// Far-side model of the cell pins: other drivers, and a floating level when nobody drives
`timescale 1ns/10ps
module pin_model #(
   parameter int CELLS = 10
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Block side of the pins
   input wire logic [CELLS-1:0] pin_out,
   input wire logic [CELLS-1:0] pin_oe,
   // Outside drivers
   input wire logic [CELLS-1:0] drv_data,
   input wire logic [CELLS-1:0] drv_en,
   // Resolved pin level
   output logic [CELLS-1:0] pin_in
);
   logic [CELLS-1:0] last_r; // Level seen on the last edge
   // Block driver wins, then outside data, else a floating pin flips so a stale value never passes
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv_en & drv_data)
      | (~pin_oe & ~drv_en & ~last_r);
   // Remember the last level for the floating case
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         last_r <= '0;
      end else begin
         last_r <= pin_in;
      end
   end
endmodule

// ### logic_array_sva.sv
// Checker of bus answers and reset levels at the logic array ports
`timescale 1ns/10ps
module logic_array_sva #(
   parameter int CELLS = 10
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Cell pins
   input wire logic [CELLS-1:0] pin_out,
   input wire logic [CELLS-1:0] pin_oe,
   // Bus write
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Bus read
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   // Both write channels taken at one edge
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // Read address taken
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   // The inner reset copy lags two edges, so the cells must still read clear then
   reset_clear_a: assert property ($rose(rst_b) |->
      (pin_oe == '0 && pin_out == '0)[*2])
      else $error("cell outputs not clear after reset");
   write_answer_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   read_answer_a: assert property (rd_taken |=> s_axi_rvalid)
      else $error("read data late");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
   error_data_a: assert property (s_axi_rvalid && s_axi_rresp == macrocell_pkg::RESP_SLVERR
      |-> s_axi_rdata == 32'h0) else $error("error read carries data");
endmodule
bind logic_array_top logic_array_sva #(.CELLS(CELLS)) sva (.clock, .rst_b, .pin_out, .pin_oe,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready);

// ### tb.sv
// Self-checking bench of the logic array: bus, modes, preload, programming, protect
`timescale 1ns/10ps
module tb;
   logic clock, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, vb;
   logic [11:0] logic_in;
   logic [9:0] pin_in, pin_out, pin_oe, drv_data, drv_en;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd, cfg, pl, c;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [15:0] loc;
   integer seed, mismatches, checks;
   // Device under test and the pins beyond it
   logic_array_top dut (.clock, .rst_b, .logic_in, .pin_in, .pin_out, .pin_oe, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   pin_model pm (.clock, .rst_b, .pin_out, .pin_oe, .drv_data, .drv_en, .pin_in);
   // Free-running 50 MHz clock
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   // Expected config readback: only the two ten-bit fields exist
   function automatic logic [31:0] exp_cfg(input logic [31:0] d);
      return d & 32'h03ff03ff;
   endfunction
   // Expected status after preload: pins and registers both carry the data
   function automatic logic [31:0] exp_status(input logic [31:0] p);
      return (p << 16) | p;
   endfunction
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Write: ready for the response is raised once both valids drop, in the same cycle as the response, so the slave never holds it
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b0;
      forever begin
         @(posedge clock);
         if (s_axi_bvalid && s_axi_bready) break;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (!s_axi_awvalid && !s_axi_wvalid) s_axi_bready <= 1'b1;
      end
      rs = s_axi_bresp;
   endtask
   task automatic rdr(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b0;
      forever begin
         @(posedge clock);
         if (s_axi_rvalid && s_axi_rready) break;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (!s_axi_arvalid) s_axi_rready <= 1'b1;
      end
      rd = s_axi_rdata;
      rs = s_axi_rresp;
   endtask
   // Address, then program, inhibit and verify; leaves the verify bit in vb
   task automatic prog(input logic [15:0] l, input logic d, input logic [1:0] arr);
      logic_in <= 12'($random(seed));
      wr(macrocell_pkg::ADDR_PROG_ADDR, {16'h0, l});
      wr(macrocell_pkg::ADDR_PROG_CMD, {22'h0, arr, 3'h0, d, 2'h0, macrocell_pkg::STEP_PROGRAM});
      wr(macrocell_pkg::ADDR_PROG_CMD, {22'h0, arr, 3'h0, d, 2'h0, macrocell_pkg::STEP_INHIBIT});
      wr(macrocell_pkg::ADDR_PROG_CMD, {22'h0, arr, 3'h0, d, 2'h0, macrocell_pkg::STEP_VERIFY});
      rdr(macrocell_pkg::ADDR_STATUS);
      vb = rd[26];
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      #400000;
      mismatches++;
      give_verdict;
   end
   // Main sequence
   initial begin
      seed = 32'h0a7a;
      mismatches = 0;
      checks = 0;
      rst_b = 1'b0;
      {logic_in, drv_data, drv_en, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} = '0;
      s_axi_wstrb = 4'hf;
      repeat (20) @(posedge clock);
      rst_b <= 1'b1;
      repeat (6) @(posedge clock); // Settle before any mode change
      rdr(macrocell_pkg::ADDR_ID);
      chk("id", macrocell_pkg::ID_VALUE, rd);
      rdr(8'h18);
      chk("bad read resp", 32'(macrocell_pkg::RESP_SLVERR), 32'(rs));
      chk("bad read data", 32'h0, rd);
      wr(8'h1c, $random(seed));
      chk("bad write resp", 32'(macrocell_pkg::RESP_SLVERR), 32'(rs));
      $display("test bus done");
      // Every mode in turn; the loop ends in preload
      for (int m = 0; m < 5; m++) begin
         wr(macrocell_pkg::ADDR_CONTROL, 32'(m));
         rdr(macrocell_pkg::ADDR_CONTROL);
         chk("mode", 32'(m), rd & 32'h7);
         chk("test pin enable", (m == 2) ? 32'h200 : ((m == 3) ? 32'h1 : 32'h0),
             32'(pin_oe));
      end
      repeat (3) @(posedge clock);
      chk("drivers in preload", 32'h0, 32'(pin_oe));
      pl = 32'($random(seed)) & 32'h3ff;
      drv_data <= pl[9:0];
      drv_en <= '1;
      repeat (6) @(posedge clock);
      rdr(macrocell_pkg::ADDR_STATUS);
      chk("preload", exp_status(pl), rd & 32'h03ff03ff);
      drv_en <= '0;
      @(posedge clock);
      $display("test preload done");
      // Reset in mid-run, still in preload, clears the registers and the mode
      rst_b <= 1'b0;
      repeat (3) @(posedge clock);
      rst_b <= 1'b1;
      repeat (6) @(posedge clock);
      rdr(macrocell_pkg::ADDR_CONTROL);
      chk("mode after reset", 32'h0, rd & 32'h7);
      rdr(macrocell_pkg::ADDR_STATUS);
      chk("regs after reset", 32'h0, rd & 32'h03ff0000);
      cfg = $random(seed);
      wr(macrocell_pkg::ADDR_CELL_CFG, cfg);
      rdr(macrocell_pkg::ADDR_CELL_CFG);
      chk("cell config", exp_cfg(cfg), rd);
      // Blank terms and cleared registers leave each pin at its polarity level
      chk("pins follow polarity", exp_cfg(cfg) & 32'h3ff, 32'(pin_out));
      c = $unsigned($random(seed));
      loc = {8'(c % 22), 4'(c % 10), 4'((c >> 8) % 12)};
      prog(loc, 1'b1, macrocell_pkg::ARR_NORMAL);
      chk("verify one", 32'h1, 32'(vb));
      prog(loc + 16'h1600, 1'b0, macrocell_pkg::ARR_NORMAL);
      chk("verify zero", 32'h0, 32'(vb));
      $display("test programming done");
      // Protect: config and normal array locked, test array still open
      wr(macrocell_pkg::ADDR_CONTROL, 32'h10);
      rdr(macrocell_pkg::ADDR_CONTROL);
      chk("protect bit", 32'h10, rd & 32'h10);
      wr(macrocell_pkg::ADDR_CELL_CFG, ~cfg);
      rdr(macrocell_pkg::ADDR_CELL_CFG);
      chk("locked config", exp_cfg(cfg), rd);
      prog(loc + 16'h0001, 1'b1, macrocell_pkg::ARR_NORMAL);
      chk("locked verify", 32'h0, 32'(vb));
      prog(loc, 1'b1, macrocell_pkg::ARR_TEST);
      chk("test array verify", 32'h1, 32'(vb));
      $display("test protect done");
      give_verdict;
   end
endmodule
